// [inc/ptd_pkg.sv]
// Constants, field positions and carrier types for the punch-through texel block decoder.
package ptd_pkg;

	// Block field positions shared by all modes; the flip bit is used in differential mode only.
	localparam int PTD_BLK_W = 64;
	localparam int PTD_FLIP_BIT = 32;
	localparam int PTD_OPAQUE_BIT = 33;
	localparam int PTD_IDX_LSB_BASE = 0;
	localparam int PTD_IDX_MSB_BASE = 16;

	// Differential mode fields (least significant bit of each).
	localparam int PTD_RED_BASE_LSB = 59;
	localparam int PTD_RED_DELTA_CODE_LSB = 56;
	localparam int PTD_GREEN_BASE_LSB = 51;
	localparam int PTD_GREEN_DELTA_CODE_LSB = 48;
	localparam int PTD_BLUE_BASE_LSB = 43;
	localparam int PTD_BLUE_DELTA_CODE_LSB = 40;
	localparam int PTD_TABLE_ONE_LSB = 37;
	localparam int PTD_TABLE_TWO_LSB = 34;

	// T mode fields.
	localparam int PTD_T_RED_UPPER_FRAGMENT_LSB = 59;
	localparam int PTD_T_RED_LOWER_FRAGMENT_LSB = 56;
	localparam int PTD_T_GREEN1_LSB = 52;
	localparam int PTD_T_BLUE1_LSB = 48;
	localparam int PTD_T_RED2_LSB = 44;
	localparam int PTD_T_GREEN2_LSB = 40;
	localparam int PTD_T_BLUE2_LSB = 36;
	localparam int PTD_T_DISTANCE_UPPER_FIELD_LSB = 34;
	localparam int PTD_DISTANCE_LOWER_FIELD_BIT = 32;

	// H mode fields.
	localparam int PTD_H_RED1_LSB = 59;
	localparam int PTD_H_GREEN_UPPER_FRAGMENT_LSB = 56;
	localparam int PTD_H_GREEN_LOWER_FRAGMENT_BIT = 52;
	localparam int PTD_H_BLUE_UPPER_FRAGMENT_BIT = 51;
	localparam int PTD_H_BLUE_LOWER_FRAGMENT_LSB = 47;
	localparam int PTD_H_RED2_LSB = 43;
	localparam int PTD_H_GREEN2_LSB = 39;
	localparam int PTD_H_BLUE2_LSB = 35;
	localparam int PTD_H_DISTANCE_UPPER_FIELD_BIT = 34;

	// Modifier magnitudes per table index, outer and inner entries.
	localparam logic [7:0] PTD_MOD_LARGE [0:7] = '{8'h08, 8'h11, 8'h1D, 8'h2A, 8'h3C, 8'h50, 8'h6A, 8'hB7};
	localparam logic [7:0] PTD_MOD_SMALL [0:7] = '{8'h02, 8'h05, 8'h09, 8'h0D, 8'h12, 8'h18, 8'h21, 8'h2F};
	// Shared distance table for T and H modes.
	localparam logic [7:0] PTD_DISTANCE [0:7] = '{8'h03, 8'h06, 8'h0B, 8'h10, 8'h17, 8'h20, 8'h29, 8'h40};

	// Register map, byte addresses.
	localparam logic [7:0] PTD_REG_CTRL = 8'h00;
	localparam logic [7:0] PTD_REG_STAT = 8'h04;
	localparam logic [7:0] PTD_REG_LAST = 8'h08;
	localparam int PTD_CTRL_EN_BIT = 0;
	localparam int PTD_STAT_COUNT_LSB = 16;
	localparam logic PTD_CTRL_EN_RST = 1'b1;
	localparam logic [15:0] PTD_COUNT_RST = 16'h0000;

	typedef enum logic [1:0] {
		PTD_MODE_DIFF = 2'b00,
		PTD_MODE_T = 2'b01,
		PTD_MODE_H = 2'b11,
		PTD_MODE_PLANAR = 2'b10
	} ptd_mode_t;

	typedef struct packed {
		logic [7:0] r;
		logic [7:0] g;
		logic [7:0] b;
		logic [7:0] a;
	} ptd_texel_t;

	typedef struct packed {
		logic [63:0] blk;
		logic [3:0] pix;
	} ptd_req_t;

	typedef struct packed {
		ptd_mode_t mode;
		ptd_texel_t texel;
	} ptd_dec_t;

	localparam ptd_texel_t PTD_PLANAR_TEXEL = '{r: 8'h00, g: 8'h00, b: 8'h00, a: 8'hFF};

	typedef struct packed {
		logic out_valid;
		ptd_texel_t texel;
		ptd_mode_t mode;
		logic enable;
		logic [15:0] count;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} ptd_state_t;

	localparam ptd_state_t PTD_STATE_RST = '{out_valid: 1'b0, texel: 32'h0000_0000, mode: PTD_MODE_DIFF,
		enable: PTD_CTRL_EN_RST, count: PTD_COUNT_RST, prdata: 32'h0000_0000, pready: 1'b0, pslverr: 1'b0};

endpackage

// [rtl/ptd_decoder.sv]
// Punch-through texel block decoder: one 64-bit block and pixel number in, one RGBA texel out, APB control.
// What this block does
// RULE1: Differential decoding when every base plus delta sum stays within 0..31.
// RULE2: Bit 32 splits the block into left/right or top/bottom halves.
// RULE3: Five-bit codewords widen to eight by appending their top three bits.
// RULE4: Second half base is codeword plus signed 3-bit delta, widened alike.
// RULE5: First half table index from bits 39..37, second from 36..34.
// RULE6: Table index picks a modifier row; bit 33 chooses opaque or non-opaque set.
// RULE7: Opaque rows are fixed constants, hardcoded.
// RULE8: Non-opaque rows keep outer magnitudes and have zero inner entries.
// RULE9: Pixel index bits sit at fixed positions regardless of split.
// RULE10: Opaque: 11 large negative, 10 small negative, 00 small positive, 01 large positive.
// RULE11: Non-opaque: 11 large negative, 01 large positive, 10 and 00 zero.
// RULE12: Modifier adds to red, green, blue; each sum clamps to 0..255.
// RULE13: Alpha 255 if opaque; else index 10 gives all-zero texel.
// RULE14: T mode first red is upper fragment shifted two, ORed with lower.
// RULE15: H mode first green and blue are built from shifted fragments.
// RULE16: Four-bit channels widen to eight by repeating the nibble.
// RULE17: T mode paint zero is base one, paint two is base two.
// RULE18: T mode distance index is upper field shifted one ORed with lower bit.
// RULE19: T mode paint one is base two plus distance, paint three minus.
// RULE20: Differential delta adder needs no overflow handling.
// RULE21: Every T and H paint channel clamps to 0..255.
// RULE22: T and H: non-opaque index 10 zeroes the texel, else alpha 255.
// RULE23: H distance index low bit is base one value at least base two.
// RULE24: T and H pixel index directly selects the paint colour number.
// RULE25: Distance lookup holds eight fixed constants, index five is 32.
// RULE26: One texel per requested pixel, with a valid strobe; ready stays high while i_ce is low, so a request taken then gives no texel.
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/100ps
`default_nettype none

module ptd_decoder #(
	parameter int ADDR_W = 8
) (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_ce,
	input wire logic i_req_valid,
	input wire ptd_pkg::ptd_req_t i_req,
	output logic o_req_ready,
	output logic o_valid,
	output ptd_pkg::ptd_texel_t o_texel,
	output ptd_pkg::ptd_mode_t o_mode,
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr
);

	function automatic logic [7:0] widen_five_to_eight(input logic [4:0] c);
		return {c, c[4:2]}; // [RULE3]
	endfunction

	function automatic logic [7:0] widen_four_to_eight(input logic [3:0] c);
		return {c, c}; // [RULE16]
	endfunction

	function automatic logic [7:0] add_clamp(input logic [7:0] base, input logic signed [9:0] off);
		logic signed [9:0] s;
		s = $signed({2'b00, base}) + off;
		if (s < 10'sh000) begin
			return 8'h00; // [RULE12] [RULE21]
		end else if (s > 10'sh0FF) begin
			return 8'hFF;
		end
		return s[7:0];
	endfunction

	function automatic ptd_pkg::ptd_dec_t ptd_decode(input logic [63:0] b, input logic [3:0] p);
		logic msb;
		logic lsb;
		logic opq;
		logic sub;
		logic lo_bit;
		logic [5:0] sr;
		logic [5:0] sg;
		logic [5:0] sb;
		logic [2:0] tix;
		logic [2:0] dix;
		logic [7:0] mag;
		logic [7:0] br;
		logic [7:0] bg;
		logic [7:0] bb;
		logic [7:0] r1;
		logic [7:0] g1;
		logic [7:0] b1;
		logic [7:0] r2;
		logic [7:0] g2;
		logic [7:0] b2;
		logic signed [9:0] off;
		ptd_pkg::ptd_dec_t d;
		msb = b[ptd_pkg::PTD_IDX_MSB_BASE + p]; // [RULE9] [RULE24]
		lsb = b[ptd_pkg::PTD_IDX_LSB_BASE + p];
		opq = b[ptd_pkg::PTD_OPAQUE_BIT];
		sub = 1'b0;
		lo_bit = 1'b0;
		tix = 3'h0;
		dix = 3'h0;
		mag = 8'h00;
		off = 10'sh000;
		r1 = 8'h00;
		g1 = 8'h00;
		b1 = 8'h00;
		r2 = 8'h00;
		g2 = 8'h00;
		b2 = 8'h00;
		// Sums are one bit wider so that leaving 0..31 shows in the top bit either way.
		sr = {1'b0, b[ptd_pkg::PTD_RED_BASE_LSB +: 5]}
			+ {{3{b[ptd_pkg::PTD_RED_DELTA_CODE_LSB + 2]}}, b[ptd_pkg::PTD_RED_DELTA_CODE_LSB +: 3]};
		sg = {1'b0, b[ptd_pkg::PTD_GREEN_BASE_LSB +: 5]}
			+ {{3{b[ptd_pkg::PTD_GREEN_DELTA_CODE_LSB + 2]}}, b[ptd_pkg::PTD_GREEN_DELTA_CODE_LSB +: 3]};
		sb = {1'b0, b[ptd_pkg::PTD_BLUE_BASE_LSB +: 5]}
			+ {{3{b[ptd_pkg::PTD_BLUE_DELTA_CODE_LSB + 2]}}, b[ptd_pkg::PTD_BLUE_DELTA_CODE_LSB +: 3]};
		if (sr[5]) begin
			d.mode = ptd_pkg::PTD_MODE_T;
		end else if (sg[5]) begin
			d.mode = ptd_pkg::PTD_MODE_H;
		end else if (sb[5]) begin
			d.mode = ptd_pkg::PTD_MODE_PLANAR;
		end else begin
			d.mode = ptd_pkg::PTD_MODE_DIFF; // [RULE1]
		end
		br = 8'h00;
		bg = 8'h00;
		bb = 8'h00;
		case (d.mode)
			ptd_pkg::PTD_MODE_DIFF: begin
				// Pixel p sits at column p[3:2] and row p[1:0].
				sub = b[ptd_pkg::PTD_FLIP_BIT] ? p[1] : p[3]; // [RULE2]
				// Sums here are known to be in range, so only the low five bits are kept.
				br = widen_five_to_eight(sub ? sr[4:0] : b[ptd_pkg::PTD_RED_BASE_LSB +: 5]); // [RULE4] [RULE20]
				bg = widen_five_to_eight(sub ? sg[4:0] : b[ptd_pkg::PTD_GREEN_BASE_LSB +: 5]);
				bb = widen_five_to_eight(sub ? sb[4:0] : b[ptd_pkg::PTD_BLUE_BASE_LSB +: 5]);
				tix = sub ? b[ptd_pkg::PTD_TABLE_TWO_LSB +: 3] : b[ptd_pkg::PTD_TABLE_ONE_LSB +: 3]; // [RULE5]
				case ({msb, lsb}) // [RULE6] [RULE7] [RULE8]
					2'b11: off = -$signed({2'b00, ptd_pkg::PTD_MOD_LARGE[tix]}); // [RULE10] [RULE11]
					2'b01: off = $signed({2'b00, ptd_pkg::PTD_MOD_LARGE[tix]});
					2'b10: off = opq ? -$signed({2'b00, ptd_pkg::PTD_MOD_SMALL[tix]}) : 10'sh000;
					default: off = opq ? $signed({2'b00, ptd_pkg::PTD_MOD_SMALL[tix]}) : 10'sh000;
				endcase
			end
			ptd_pkg::PTD_MODE_T: begin
				r1 = widen_four_to_eight({b[ptd_pkg::PTD_T_RED_UPPER_FRAGMENT_LSB +: 2],
					b[ptd_pkg::PTD_T_RED_LOWER_FRAGMENT_LSB +: 2]}); // [RULE14]
				g1 = widen_four_to_eight(b[ptd_pkg::PTD_T_GREEN1_LSB +: 4]);
				b1 = widen_four_to_eight(b[ptd_pkg::PTD_T_BLUE1_LSB +: 4]);
				r2 = widen_four_to_eight(b[ptd_pkg::PTD_T_RED2_LSB +: 4]);
				g2 = widen_four_to_eight(b[ptd_pkg::PTD_T_GREEN2_LSB +: 4]);
				b2 = widen_four_to_eight(b[ptd_pkg::PTD_T_BLUE2_LSB +: 4]);
				dix = {b[ptd_pkg::PTD_T_DISTANCE_UPPER_FIELD_LSB +: 2], b[ptd_pkg::PTD_DISTANCE_LOWER_FIELD_BIT]}; // [RULE18]
				mag = ptd_pkg::PTD_DISTANCE[dix]; // [RULE25]
				br = r2;
				bg = g2;
				bb = b2;
				case ({msb, lsb}) // [RULE17] [RULE19] [RULE24]
					2'b00: begin
						br = r1;
						bg = g1;
						bb = b1;
					end
					2'b01: off = $signed({2'b00, mag});
					2'b11: off = -$signed({2'b00, mag});
					default: off = 10'sh000;
				endcase
			end
			ptd_pkg::PTD_MODE_H: begin
				r1 = widen_four_to_eight(b[ptd_pkg::PTD_H_RED1_LSB +: 4]);
				g1 = widen_four_to_eight({b[ptd_pkg::PTD_H_GREEN_UPPER_FRAGMENT_LSB +: 3],
					b[ptd_pkg::PTD_H_GREEN_LOWER_FRAGMENT_BIT]}); // [RULE15]
				b1 = widen_four_to_eight({b[ptd_pkg::PTD_H_BLUE_UPPER_FRAGMENT_BIT],
					b[ptd_pkg::PTD_H_BLUE_LOWER_FRAGMENT_LSB +: 3]});
				r2 = widen_four_to_eight(b[ptd_pkg::PTD_H_RED2_LSB +: 4]);
				g2 = widen_four_to_eight(b[ptd_pkg::PTD_H_GREEN2_LSB +: 4]);
				b2 = widen_four_to_eight(b[ptd_pkg::PTD_H_BLUE2_LSB +: 4]);
				lo_bit = ({r1, g1, b1} >= {r2, g2, b2}); // [RULE23]
				dix = {b[ptd_pkg::PTD_H_DISTANCE_UPPER_FIELD_BIT], b[ptd_pkg::PTD_DISTANCE_LOWER_FIELD_BIT], lo_bit};
				mag = ptd_pkg::PTD_DISTANCE[dix];
				br = msb ? r2 : r1; // [RULE24]
				bg = msb ? g2 : g1;
				bb = msb ? b2 : b1;
				off = lsb ? -$signed({2'b00, mag}) : $signed({2'b00, mag});
			end
			default: begin
				off = 10'sh000;
			end
		endcase
		d.texel.r = add_clamp(br, off); // [RULE12] [RULE21]
		d.texel.g = add_clamp(bg, off);
		d.texel.b = add_clamp(bb, off);
		d.texel.a = 8'hFF;
		if (d.mode == ptd_pkg::PTD_MODE_PLANAR) begin
			// Planar blocks are not decoded here; a fixed opaque texel marks them.
			d.texel = ptd_pkg::PTD_PLANAR_TEXEL;
		end else if (!opq && msb && !lsb) begin
			d.texel = 32'h0000_0000; // [RULE13] [RULE22]
		end
		return d;
	endfunction

	ptd_pkg::ptd_state_t st;
	ptd_pkg::ptd_state_t next_st;
	ptd_pkg::ptd_dec_t dec;
	logic accept;
	logic apb_setup;
	logic apb_commit;
	logic hit_ctrl;
	logic hit_stat;
	logic hit_last;

	assign dec = ptd_decode(i_req.blk, i_req.pix);
	// Requests are taken only while the stream is enabled; the ready output mirrors that flop.
	assign accept = i_req_valid && st.enable;
	// The answer comes one cycle into the access phase; writes land on the edge that samples pready.
	assign apb_setup = i_psel && i_penable && !st.pready;
	assign apb_commit = i_psel && i_penable && st.pready && i_pwrite;
	assign hit_ctrl = (i_paddr == ADDR_W'(ptd_pkg::PTD_REG_CTRL));
	assign hit_stat = (i_paddr == ADDR_W'(ptd_pkg::PTD_REG_STAT));
	assign hit_last = (i_paddr == ADDR_W'(ptd_pkg::PTD_REG_LAST));

	always_comb begin
		next_st = st;
		next_st.out_valid = 1'b0;
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (accept) begin
			next_st.out_valid = 1'b1; // [RULE26]
			next_st.texel = dec.texel;
			next_st.mode = dec.mode;
		end
		if (apb_setup) begin
			next_st.pready = 1'b1;
			next_st.prdata = 32'h0000_0000;
			if (hit_ctrl) begin
				next_st.prdata[ptd_pkg::PTD_CTRL_EN_BIT] = st.enable;
			end else if (hit_stat) begin
				next_st.prdata = {st.count, 14'h0000, st.mode};
			end else if (hit_last) begin
				next_st.prdata = st.texel;
			end else begin
				next_st.pslverr = 1'b1;
			end
		end
		if (apb_commit && hit_ctrl && i_pstrb[0]) begin
			next_st.enable = i_pwdata[ptd_pkg::PTD_CTRL_EN_BIT];
		end
		// A write to status clears the texel count; a texel finished in the same cycle still counts.
		if (apb_commit && hit_stat) begin
			next_st.count = accept ? 16'h0001 : 16'h0000;
		end else if (accept) begin
			next_st.count = st.count + 16'h0001;
		end
		if (!i_ce) begin
			next_st = st;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (!i_nrst) begin
			st <= ptd_pkg::PTD_STATE_RST;
		end else begin
			st <= next_st;
		end
	end

	assign o_req_ready = st.enable;
	assign o_valid = st.out_valid;
	assign o_texel = st.texel;
	assign o_mode = st.mode;
	assign o_prdata = st.prdata;
	assign o_pready = st.pready;
	assign o_pslverr = st.pslverr;

	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (!i_nrst);

	a_valid_after_accept: assert property (i_ce && accept |=> o_valid) // [RULE26]
		else $error("accepted request did not raise valid");

	a_punch_rgb_zero: assert property (o_valid && o_texel.a == 8'h00 |-> o_texel[31:8] == 24'h000000) // [RULE13]
		else $error("transparent texel has colour");

	a_opaque_alpha_full: assert property (i_ce && accept && i_req.blk[ptd_pkg::PTD_OPAQUE_BIT]
		|=> o_texel.a == 8'hFF) // [RULE13]
		else $error("opaque block gave alpha below full");

	a_punch_index_ten: assert property (i_ce && accept && dec.mode != ptd_pkg::PTD_MODE_PLANAR
		&& !i_req.blk[ptd_pkg::PTD_OPAQUE_BIT] && i_req.blk[ptd_pkg::PTD_IDX_MSB_BASE + i_req.pix]
		&& !i_req.blk[i_req.pix] |=> o_texel == 32'h0000_0000) // [RULE22]
		else $error("non-opaque index two not punched through");

	a_diff_mode_pick: assert property (i_ce && accept && i_req.blk[63:40] == 24'h000000 |=> o_mode == ptd_pkg::PTD_MODE_DIFF) // [RULE1]
		else $error("in-range sums did not pick differential decoding");

	a_diff_clamp_top: assert property (i_ce && accept && dec.mode == ptd_pkg::PTD_MODE_DIFF
		&& !i_req.blk[ptd_pkg::PTD_FLIP_BIT] && !i_req.pix[3]
		&& i_req.blk[ptd_pkg::PTD_RED_BASE_LSB +: 5] == 5'h1F
		&& i_req.blk[ptd_pkg::PTD_IDX_MSB_BASE + i_req.pix] == 1'b0 && i_req.blk[i_req.pix]
		|=> o_texel.r == 8'hFF) // [RULE12]
		else $error("top red codeword plus positive modifier not clamped to full");

	a_t_paint_zero: assert property (i_ce && accept && dec.mode == ptd_pkg::PTD_MODE_T
		&& i_req.blk[ptd_pkg::PTD_IDX_MSB_BASE + i_req.pix] == 1'b0 && i_req.blk[i_req.pix] == 1'b0
		|=> o_texel.g == {2{$past(i_req.blk[ptd_pkg::PTD_T_GREEN1_LSB +: 4])}}) // [RULE17]
		else $error("T paint colour zero is not the widened first base");

	a_apb_one_wait: assert property (i_psel && i_penable && !o_pready |=> o_pready ##1 !o_pready) // [RULE26]
		else $error("APB answer not given after exactly one wait cycle");

	a_count_step: assert property (i_ce && accept && !apb_commit |=> st.count == $past(st.count) + 16'h0001) // [RULE26]
		else $error("texel count did not advance");

	a_freeze_ce: assert property (!i_ce |=> $stable(o_texel) && $stable(st.count) && $stable(o_mode)) // [RULE26]
		else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// [test/ptd_decoder_tb.sv]
// Self-checking bench for the punch-through texel block decoder.
`timescale 1ns/100ps
`default_nettype none
module ptd_decoder_tb;
	logic i_ref_clk = 1'b0;
	logic i_nrst = 1'b0;
	logic i_psel = 1'b0;
	logic i_penable = 1'b0;
	logic i_pwrite = 1'b0;
	logic [7:0] i_paddr = 8'h00;
	logic [7:0] dens = 8'h00;
	logic [31:0] i_pwdata = 32'h0000_0000;
	logic [3:0] i_pstrb = 4'h0;
	logic i_req_valid, o_req_ready, o_valid, o_pready, o_pslverr, err;
	ptd_pkg::ptd_req_t i_req;
	ptd_pkg::ptd_texel_t o_texel;
	ptd_pkg::ptd_mode_t o_mode;
	logic [31:0] o_prdata, rd;
	int num_errors = 0;
	int checks = 0;
	int cycles = 0;
	int cnt_m = 0;
	logic en_m = 1'b1;
	logic pend = 1'b0;
	logic ce = 1'b1;
	logic ce_rand = 1'b0;
	ptd_pkg::ptd_dec_t exp_d, last_d = '0;
	localparam int L_TAB [8] = '{8'h08, 8'h11, 8'h1D, 8'h2A, 8'h3C, 8'h50, 8'h6A, 8'hB7};
	localparam int S_TAB [8] = '{8'h02, 8'h05, 8'h09, 8'h0D, 8'h12, 8'h18, 8'h21, 8'h2F};

	ptd_decoder u_ptd_decoder (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ce(ce), .i_req_valid(i_req_valid),
		.i_req(i_req), .o_req_ready(o_req_ready), .o_valid(o_valid), .o_texel(o_texel), .o_mode(o_mode),
		.i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
		.i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr));
	ptd_fetch_model u_ptd_fetch_model (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_ready(o_req_ready),
		.i_density(dens), .o_valid(i_req_valid), .o_req(i_req));

	function automatic int cl(int v);
		return v < 0 ? 0 : (v > 8'hFF ? 8'hFF : v);
	endfunction

	function automatic ptd_pkg::ptd_dec_t model(logic [63:0] b, logic [3:0] p);
		int r, g, u, dr, dg, du, k, d;
		int c [2][3];
		logic [1:0] ix;
		logic [2:0] t;
		logic hv;
		ptd_pkg::ptd_dec_t o;
		ix = {b[5'h10 + p], b[p]};
		r = b[63:59];
		g = b[55:51];
		u = b[47:43];
		dr = $signed(b[58:56]);
		dg = $signed(b[50:48]);
		du = $signed(b[42:40]);
		o.texel.a = 8'hFF;
		k = 0;
		if (r + dr < 0 || r + dr > 8'h1F) begin
			o.mode = ptd_pkg::PTD_MODE_T;
			c[0] = '{{b[60:59], b[57:56]} * 8'h11, b[55:52] * 8'h11, b[51:48] * 8'h11};
			c[1] = '{b[47:44] * 8'h11, b[43:40] * 8'h11, b[39:36] * 8'h11};
			d = ptd_pkg::PTD_DISTANCE[{b[35:34], b[32]}];
			hv = ix != 2'b00;
			k = ix == 2'b01 ? d : (ix == 2'b11 ? -d : 0);
		end else if (g + dg < 0 || g + dg > 8'h1F) begin
			o.mode = ptd_pkg::PTD_MODE_H;
			c[0] = '{b[62:59] * 8'h11, {b[58:56], b[52]} * 8'h11, {b[51], b[49:47]} * 8'h11};
			c[1] = '{b[46:43] * 8'h11, b[42:39] * 8'h11, b[38:35] * 8'h11};
			t = {b[34], b[32], (c[0][0] << 5'h10) + (c[0][1] << 4'h8) + c[0][2] >=
				(c[1][0] << 5'h10) + (c[1][1] << 4'h8) + c[1][2]};
			d = ptd_pkg::PTD_DISTANCE[t];
			hv = ix[1];
			k = ix[0] ? -d : d;
		end else if (u + du < 0 || u + du > 8'h1F) begin
			o.mode = ptd_pkg::PTD_MODE_PLANAR;
			c[0] = '{0, 0, 0};
			hv = 1'b0;
		end else begin
			o.mode = ptd_pkg::PTD_MODE_DIFF;
			hv = b[32] ? p[1] : p[3];
			if (hv) begin
				r += dr;
				g += dg;
				u += du;
			end
			t = hv ? b[36:34] : b[39:37];
			c[hv] = '{(r << 3) | (r >> 2), (g << 3) | (g >> 2), (u << 3) | (u >> 2)};
			k = ix == 2'b11 ? -L_TAB[t] : (ix == 2'b01 ? L_TAB[t] :
				(!b[33] ? 0 : (ix[1] ? -S_TAB[t] : S_TAB[t])));
		end
		o.texel.r = 8'(cl(c[hv][0] + k));
		o.texel.g = 8'(cl(c[hv][1] + k));
		o.texel.b = 8'(cl(c[hv][2] + k));
		if (!b[33] && ix == 2'b10 && o.mode != ptd_pkg::PTD_MODE_PLANAR) o.texel = '0;
		return o;
	endfunction

	task automatic cmp_w(input logic [31:0] got, input logic [31:0] ex, input string what);
		checks++;
		if (got !== ex) begin
			num_errors++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, ex);
		end
	endtask

	task automatic cmp_d(input ptd_pkg::ptd_dec_t got, input ptd_pkg::ptd_dec_t ex);
		checks++;
		if (got !== ex) begin
			num_errors++;
			$display("wrong value at %0t: texel got %h expected %h", $time, got, ex);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		@(posedge i_ref_clk);
		i_psel <= 1'b1;
		i_penable <= 1'b0;
		i_pwrite <= wr;
		i_paddr <= a;
		i_pwdata <= wd;
		i_pstrb <= 4'hF;
		@(posedge i_ref_clk);
		i_penable <= 1'b1;
		do @(posedge i_ref_clk); while (o_pready !== 1'b1);
		rd = o_prdata;
		err = o_pslverr;
		if (wr && a == ptd_pkg::PTD_REG_CTRL) en_m <= wd[0];
		if (wr && a == ptd_pkg::PTD_REG_STAT) cnt_m = 0;
		i_psel <= 1'b0;
		i_penable <= 1'b0;
	endtask

	task automatic rchk(input logic wr, input logic [7:0] a, input logic [31:0] wd, input logic [31:0] ex,
		input logic ee);
		apb(wr, a, wd);
		cmp_w({31'h0, err}, {31'h0, ee}, "slave error");
		if (!wr) cmp_w(rd, ex, "read data");
	endtask

	always #25 i_ref_clk = ~i_ref_clk;

	// The ceiling is more than twice the length of the planned traffic.
	always @(posedge i_ref_clk) begin
		cycles++;
		if (cycles == 16'h1388) begin
			num_errors++;
			$display("wrong value at %0t: run did not finish", $time);
			end_sim();
		end
	end

	// Clock enable drops at random only in stream phases, so register accesses never stall.
	always @(posedge i_ref_clk) begin
		ce <= ce_rand ? 1'($urandom) : 1'b1;
	end

	always @(posedge i_ref_clk) begin
		if (i_nrst) cmp_w({31'h0, o_valid}, {31'h0, pend}, "valid strobe");
		if (i_nrst && pend) cmp_d({o_mode, o_texel}, exp_d);
		// A frozen edge keeps the strobe and texel as they were, so the expectation is held too.
		if (ce || !i_nrst) pend = i_nrst && i_req_valid && en_m;
		if (pend && ce) begin
			exp_d = model(i_req.blk, i_req.pix);
			last_d = exp_d;
			cnt_m++;
		end
	end

	initial begin
		void'($urandom(20));
		repeat (12) @(posedge i_ref_clk);
		i_nrst <= 1'b1;
		@(posedge i_ref_clk);
		cmp_w({31'h0, o_req_ready}, 32'h1, "ready");
		rchk(1'b0, ptd_pkg::PTD_REG_CTRL, 32'h0, 32'h1, 1'b0);
		rchk(1'b0, ptd_pkg::PTD_REG_STAT, 32'h0, 32'h0, 1'b0);
		rchk(1'b0, ptd_pkg::PTD_REG_LAST, 32'h0, 32'h0, 1'b0);
		foreach (L_TAB[i]) begin
			dens <= i[0] ? 8'hFF : 8'h30;
			ce_rand <= i[2];
			repeat (200) @(posedge i_ref_clk);
		end
		ce_rand <= 1'b0;
		dens <= 8'h00;
		repeat (4) @(posedge i_ref_clk);
		rchk(1'b0, ptd_pkg::PTD_REG_STAT, 32'h0, {cnt_m[15:0], 14'h0, last_d.mode}, 1'b0);
		rchk(1'b1, ptd_pkg::PTD_REG_LAST, 32'hFFFF_FFFF, 32'h0, 1'b0);
		rchk(1'b0, ptd_pkg::PTD_REG_LAST, 32'h0, last_d.texel, 1'b0);
		rchk(1'b1, ptd_pkg::PTD_REG_STAT, 32'h0, 32'h0, 1'b0);
		rchk(1'b0, ptd_pkg::PTD_REG_STAT, 32'h0, {16'h0, 14'h0, last_d.mode}, 1'b0);
		rchk(1'b1, ptd_pkg::PTD_REG_CTRL, 32'h0, 32'h0, 1'b0);
		dens <= 8'hFF;
		repeat (100) @(posedge i_ref_clk);
		cmp_w({31'h0, o_req_ready}, 32'h0, "ready");
		rchk(1'b0, ptd_pkg::PTD_REG_STAT, 32'h0, {16'h0, 14'h0, last_d.mode}, 1'b0);
		rchk(1'b1, ptd_pkg::PTD_REG_CTRL, 32'h1, 32'h0, 1'b0);
		repeat (300) @(posedge i_ref_clk);
		dens <= 8'h00;
		rchk(1'b0, 8'h0C, 32'h0, 32'h0, 1'b1);
		rchk(1'b1, 8'h0C, 32'hFFFF_FFFF, 32'h0, 1'b1);
		repeat (4) @(posedge i_ref_clk);
		end_sim();
	end
endmodule
`default_nettype wire

// [test/ptd_fetch_model.sv]
// Block fetch stand-in that offers random compressed blocks to the decoder.
`timescale 1ns/100ps
`default_nettype none
module ptd_fetch_model (
	input wire logic i_ref_clk,
	input wire logic i_nrst,
	input wire logic i_ready,
	input wire logic [7:0] i_density,
	output logic o_valid,
	output ptd_pkg::ptd_req_t o_req
);
	initial begin
		o_valid = 1'b0;
		o_req = '0;
	end
	always @(posedge i_ref_clk) begin
		// A refused offer is held until it is taken; idle lines keep changing so stale data never looks valid.
		if (!(o_valid && !i_ready) || !i_nrst) begin
			o_valid <= i_nrst && (8'($urandom) < i_density);
			o_req <= {$urandom, $urandom, 4'($urandom)};
		end
	end
endmodule
`default_nettype wire
